// file: design/asc_pkg.sv
// Constants, field layout and shared types of the converter sequence control.
// Assumes an APB slave with 32-bit data and one word for each register.
//
// Summary of operation
// - Reference field picks supply or external references
// - Offset calibration ties both sampler inputs low
// - Scan enable walks inputs, else fixed selection
// - Fill status shows which half is filling
// - Interrupt after every N+1 completed sequences
// - Buffer mode: two halves or one buffer
// - Alternate mode: A first, then B, A, ...
// - Clock source bit selects RC or bus clock
// - Auto sample time is 1..31 conversion clocks
// - Auto sample time only used with counter trigger
// - Conversion clock is 2*(divider+1) bus clocks
// - Divider ignored while RC clock selected
// - B negative input: input 1 or low reference
// - B positive codes: inputs, sensor, reference, open
// - A negative input: input 1 or low reference
// - A positive input uses the B encoding
// - Unimplemented register bits read as zero
// - Counter trigger ends sampling after sample time
// - Scan bits include inputs, sensor, reference, ground
package asc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CTL_TWO = 8'h00;
    localparam logic [7:0] ADDR_CTL_THREE = 8'h04;
    localparam logic [7:0] ADDR_INPUT_SEL = 8'h08;
    localparam logic [7:0] ADDR_SCAN_SEL = 8'h0c;
    localparam logic [7:0] ADDR_SEQ_CTL = 8'h10;
    localparam logic [7:0] ADDR_SEQ_STAT = 8'h14;

    // ==========================================================
    // Writable bits and reset values
    localparam logic [31:0] CTL_TWO_WMASK = 32'h0000_f43f;
    localparam logic [31:0] CTL_THREE_WMASK = 32'h0000_9fff;
    localparam logic [31:0] INPUT_SEL_WMASK = 32'h8f8f_0000;
    localparam logic [31:0] SCAN_SEL_WMASK = 32'h0000_ffff;
    localparam logic [31:0] SEQ_CTL_WMASK = 32'h0000_00e4;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // ==========================================================
    // Field positions
    localparam int REF_CFG_LSB = 13;
    localparam int OFFSET_CAL_BIT = 12;
    localparam int SCAN_EN_BIT = 10;
    localparam int FILL_HALF_BIT = 7;
    localparam int SEQ_PER_IRQ_LSB = 2;
    localparam int BUF_SPLIT_BIT = 1;
    localparam int ALT_SAMPLE_BIT = 0;
    localparam int CLK_SRC_BIT = 15;
    localparam int AUTO_SAMPLE_LSB = 8;
    localparam int CLK_DIV_LSB = 0;
    localparam int NEG_B_BIT = 31;
    localparam int POS_B_LSB = 24;
    localparam int NEG_A_BIT = 23;
    localparam int POS_A_LSB = 16;
    localparam int TRIG_SRC_LSB = 5;
    localparam int AUTO_RESTART_BIT = 2;
    localparam int STOP_BIT = 1;
    localparam int START_BIT = 0;
    localparam int STAT_INDEX_LSB = 8;

    // ==========================================================
    // Codes
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam logic [3:0] SCAN_GROUND_CODE = 4'hf;

    typedef struct packed {
        logic pos_low_ref;
        logic pos_ground;
        logic [3:0] pos_code;
        logic neg_an1;
    } asc_sampler_sel_t;

    typedef struct packed {
        logic high_external;
        logic low_external;
    } asc_ref_sel_t;

    typedef enum logic [1:0] {
        ASC_IDLE,
        ASC_SAMPLE,
        ASC_CONVERT
    } asc_state_t;

    // Next set scan bit after cur, wrapping; cur when none set
    function automatic logic [3:0] asc_next_scan(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] r;
        logic [3:0] idx;
        r = cur;
        for (int i = 15; i >= 1; i--) begin
            idx = cur + 4'(i);
            if (mask[idx]) begin
                r = idx;
            end
        end
        return r;
    endfunction

    // Reference pair from the configuration field
    function automatic asc_ref_sel_t asc_ref_decode(input logic [2:0] cfg);
        asc_ref_sel_t r;
        r.high_external = ~cfg[2] & cfg[0];
        r.low_external = ~cfg[2] & cfg[1];
        return r;
    endfunction

endpackage

// file: design/asc_clk_div.sv
// Conversion clock enable generator.
// Assumes the RC tick input is already synchronous to pclk.
`timescale 1ns/1ps
module asc_clk_div (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic enable,
    input wire logic use_rc,
    input wire logic rc_tick,
    input wire logic [7:0] divider,
    // Conversion clock enable
    output logic tick
);
    import asc_pkg::*;

    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    logic tick_d;
    wire [8:0] last_count = {divider, 1'b1};

    // ==========================================================
    // Divide by 2*(divider+1), or pass the RC tick
    always_comb begin
        cnt_d = 9'h000;
        tick_d = 1'b0;
        if (enable && use_rc) begin
            tick_d = rc_tick;
        end else if (enable && cnt_q == last_count) begin
            tick_d = 1'b1;
        end else if (enable) begin
            cnt_d = cnt_q + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 9'h000;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end

endmodule

// file: design/asc_input_sel.sv
// Sampler input selection: alternate, scan and offset calibration.
// Assumes restart and advance are one-cycle pulses from the sequencer.
`timescale 1ns/1ps
module asc_input_sel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sequencer events
    input wire logic restart,
    input wire logic advance,
    // Settings
    input wire logic alternate_sample,
    input wire logic scan_enable,
    input wire logic offset_calibrate,
    input wire logic [15:0] scan_select_bits,
    input wire logic [31:0] input_select,
    // Selection
    output asc_pkg::asc_sampler_sel_t sel
);
    import asc_pkg::*;

    logic use_b_q;
    logic [3:0] scan_pos_q;

    wire use_b = alternate_sample & use_b_q;
    wire [3:0] pos_fixed = use_b ? input_select[POS_B_LSB +: 4] : input_select[POS_A_LSB +: 4];
    wire neg_fixed = use_b ? input_select[NEG_B_BIT] : input_select[NEG_A_BIT];
    wire [3:0] first_scan = asc_next_scan(scan_select_bits, 4'hf);
    wire [3:0] next_scan = asc_next_scan(scan_select_bits, scan_pos_q);

    // ==========================================================
    // Selection mux
    always_comb begin
        sel.pos_low_ref = offset_calibrate;
        sel.pos_ground = ~offset_calibrate & scan_enable & (scan_pos_q == SCAN_GROUND_CODE);
        sel.pos_code = scan_enable ? scan_pos_q : pos_fixed;
        sel.neg_an1 = ~offset_calibrate & neg_fixed;
    end

    // ==========================================================
    // Alternate and scan position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_b_q <= 1'b0;
            scan_pos_q <= 4'h0;
        end else if (restart) begin
            use_b_q <= 1'b0;
            scan_pos_q <= first_scan;
        end else if (advance) begin
            use_b_q <= ~use_b_q;
            scan_pos_q <= next_scan;
        end
    end

endmodule

// file: design/asc_adc_sequence_control.sv
// Top of the converter sequence control with its APB register file.
// Assumes the converter answers with a one-cycle done pulse,
// and that the trigger and RC tick inputs are synchronous to pclk.
`timescale 1ns/1ps
module asc_adc_sequence_control (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger and clock sources
    input wire logic ext_end_sample,
    input wire logic rc_clock_tick,
    // Converter handshake
    input wire logic conv_done,
    output logic conv_clock_tick,
    output logic sampling,
    output logic convert_start,
    // Analog selection
    output asc_pkg::asc_sampler_sel_t sampler_sel,
    output asc_pkg::asc_ref_sel_t ref_sel,
    // Result store and event
    output logic result_wr_en,
    output logic [3:0] result_wr_addr,
    output logic seq_irq
);
    import asc_pkg::*;

    // ==========================================================
    // Registers
    logic [31:0] ctl_two_q;
    logic [31:0] ctl_three_q;
    logic [31:0] input_sel_q;
    logic [31:0] scan_sel_q;
    logic [31:0] seq_ctl_q;
    logic fill_half_q;
    logic [3:0] seq_cnt_q;
    logic [3:0] wr_idx_q;
    logic [4:0] samp_cnt_q;
    asc_state_t state_q;
    asc_state_t state_d;
    asc_sampler_sel_t sel_now;
    logic div_tick;

    // ==========================================================
    // Register fields
    wire [2:0] reference_config = ctl_two_q[REF_CFG_LSB +: 3];
    wire offset_calibrate = ctl_two_q[OFFSET_CAL_BIT];
    wire scan_enable = ctl_two_q[SCAN_EN_BIT];
    wire [3:0] sequences_per_irq = ctl_two_q[SEQ_PER_IRQ_LSB +: 4];
    wire buffer_split_mode = ctl_two_q[BUF_SPLIT_BIT];
    wire alternate_sample = ctl_two_q[ALT_SAMPLE_BIT];
    wire conv_clock_source = ctl_three_q[CLK_SRC_BIT];
    wire [4:0] auto_sample_time = ctl_three_q[AUTO_SAMPLE_LSB +: 5];
    wire [7:0] conv_clock_divider = ctl_three_q[CLK_DIV_LSB +: 8];
    wire [2:0] trigger_source = seq_ctl_q[TRIG_SRC_LSB +: 3];
    wire auto_restart = seq_ctl_q[AUTO_RESTART_BIT];
    wire busy = (state_q != ASC_IDLE);

    // ==========================================================
    // APB decode; one wait state, answer from flops
    wire access = psel & penable;
    wire wr_fire = access & pready & pwrite;
    wire hit_two = (paddr == ADDR_CTL_TWO);
    wire hit_three = (paddr == ADDR_CTL_THREE);
    wire hit_in = (paddr == ADDR_INPUT_SEL);
    wire hit_scan = (paddr == ADDR_SCAN_SEL);
    wire hit_ctl = (paddr == ADDR_SEQ_CTL);
    wire hit_stat = (paddr == ADDR_SEQ_STAT);
    wire mapped = hit_two | hit_three | hit_in | hit_scan | hit_ctl | hit_stat;
    wire start_req = wr_fire & hit_ctl & pwdata[START_BIT];
    wire stop_req = wr_fire & hit_ctl & pwdata[STOP_BIT];

    // Status and fill half fold into the read words
    wire [31:0] two_rd = ctl_two_q | (32'(fill_half_q) << FILL_HALF_BIT);
    wire [31:0] ctl_rd = seq_ctl_q | 32'(busy);
    wire [31:0] stat_rd = 32'(seq_cnt_q) | (32'(wr_idx_q) << STAT_INDEX_LSB);
    wire [31:0] rd_word = hit_two ? two_rd :
                          hit_three ? ctl_three_q :
                          hit_in ? input_sel_q :
                          hit_scan ? scan_sel_q :
                          hit_ctl ? ctl_rd :
                          hit_stat ? stat_rd : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            prdata <= (access & ~pready & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Masked register writes; unimplemented bits stay zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_two_q <= REG_RESET;
            ctl_three_q <= REG_RESET;
            input_sel_q <= REG_RESET;
            scan_sel_q <= REG_RESET;
            seq_ctl_q <= REG_RESET;
        end else if (wr_fire) begin
            if (hit_two) ctl_two_q <= pwdata & CTL_TWO_WMASK;
            if (hit_three) ctl_three_q <= pwdata & CTL_THREE_WMASK;
            if (hit_in) input_sel_q <= pwdata & INPUT_SEL_WMASK;
            if (hit_scan) scan_sel_q <= pwdata & SCAN_SEL_WMASK;
            if (hit_ctl) seq_ctl_q <= pwdata & SEQ_CTL_WMASK;
        end
    end

    // ==========================================================
    // Conversion clock and input selection
    asc_clk_div u_clk_div (
        .pclk(pclk),
        .presetn(presetn),
        .enable(busy),
        .use_rc(conv_clock_source),
        .rc_tick(rc_clock_tick),
        .divider(conv_clock_divider),
        .tick(div_tick)
    );

    wire seq_done = (state_q == ASC_CONVERT) & conv_done;
    wire irq_edge = seq_done & (seq_cnt_q == sequences_per_irq);

    asc_input_sel u_input_sel (
        .pclk(pclk),
        .presetn(presetn),
        .restart(start_req & ~busy),
        .advance(seq_done),
        .alternate_sample(alternate_sample),
        .scan_enable(scan_enable),
        .offset_calibrate(offset_calibrate),
        .scan_select_bits(scan_sel_q[15:0]),
        .input_select(input_sel_q),
        .sel(sel_now)
    );

    // ==========================================================
    // Sample and convert sequencer
    wire auto_trig = (trigger_source == TRIG_AUTO);
    wire samp_last = div_tick & ((samp_cnt_q + 5'h01) >= auto_sample_time);
    wire end_sample = auto_trig ? samp_last : ext_end_sample;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ASC_IDLE: begin
                if (start_req) state_d = ASC_SAMPLE;
            end
            ASC_SAMPLE: begin
                if (stop_req) state_d = ASC_IDLE;
                else if (end_sample) state_d = ASC_CONVERT;
            end
            ASC_CONVERT: begin
                if (stop_req) state_d = ASC_IDLE;
                else if (conv_done) state_d = auto_restart ? ASC_SAMPLE : ASC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ASC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Sample time counter in conversion clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_cnt_q <= 5'h00;
        end else if (state_q != ASC_SAMPLE || end_sample) begin
            samp_cnt_q <= 5'h00;
        end else if (div_tick) begin
            samp_cnt_q <= samp_cnt_q + 5'h01;
        end
    end

    // Sequence count, write index and fill half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_cnt_q <= 4'h0;
            wr_idx_q <= 4'h0;
            fill_half_q <= 1'b0;
        end else if (start_req & ~busy) begin
            seq_cnt_q <= 4'h0;
            wr_idx_q <= 4'h0;
            fill_half_q <= 1'b0;
        end else if (irq_edge) begin
            seq_cnt_q <= 4'h0;
            wr_idx_q <= 4'h0;
            fill_half_q <= buffer_split_mode & ~fill_half_q;
        end else if (seq_done) begin
            seq_cnt_q <= seq_cnt_q + 4'h1;
            wr_idx_q <= wr_idx_q + 4'h1;
        end
    end

    // Result word: upper half bit from fill status when split
    wire [3:0] wr_addr = buffer_split_mode ? {fill_half_q, wr_idx_q[2:0]} : wr_idx_q;

    // ==========================================================
    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sampling <= 1'b0;
            convert_start <= 1'b0;
            result_wr_en <= 1'b0;
            result_wr_addr <= 4'h0;
            seq_irq <= 1'b0;
            conv_clock_tick <= 1'b0;
            sampler_sel <= '0;
            ref_sel <= '0;
        end else begin
            sampling <= (state_d == ASC_SAMPLE);
            convert_start <= (state_q == ASC_SAMPLE) & end_sample & ~stop_req;
            result_wr_en <= seq_done;
            result_wr_addr <= wr_addr;
            seq_irq <= irq_edge;
            conv_clock_tick <= div_tick;
            sampler_sel <= sel_now;
            ref_sel <= asc_ref_decode(reference_config);
        end
    end

endmodule

// file: dv/asc_checker.sv
// Port-level assertions for the converter sequence control.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module asc_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Converter side
    input wire logic ext_end_sample,
    input wire logic rc_clock_tick,
    input wire logic conv_done,
    input wire logic conv_clock_tick,
    input wire logic sampling,
    input wire logic convert_start,
    input wire asc_pkg::asc_sampler_sel_t sampler_sel,
    input wire asc_pkg::asc_ref_sel_t ref_sel,
    input wire logic result_wr_en,
    input wire logic [3:0] result_wr_addr,
    input wire logic seq_irq
);
    import asc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Shadow of the control registers
    logic [31:0] ctl2_q;
    logic [31:0] ctl3_q;
    logic [9:0] gap_q;
    logic seen_q;
    wire acc = psel & penable & pready;
    wire wr_two = acc & pwrite & (paddr == ADDR_CTL_TWO);
    wire wr_three = acc & pwrite & (paddr == ADDR_CTL_THREE);
    wire [9:0] period = {1'b0, ctl3_q[7:0], 1'b0} + 10'h002;
    wire [31:0] rmask = (paddr == ADDR_CTL_TWO) ? 32'h0000_f4bf :
        (paddr == ADDR_CTL_THREE) ? 32'h0000_9fff :
        (paddr == ADDR_INPUT_SEL) ? 32'h8f8f_0000 :
        (paddr == ADDR_SCAN_SEL) ? 32'h0000_ffff :
        (paddr == ADDR_SEQ_CTL) ? 32'h0000_00e5 :
        (paddr == ADDR_SEQ_STAT) ? 32'h0000_0f0f : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl2_q <= 32'h0;
            ctl3_q <= 32'h0;
            gap_q <= 10'h0;
            seen_q <= 1'b0;
        end else begin
            ctl2_q <= wr_two ? pwdata : ctl2_q;
            ctl3_q <= wr_three ? pwdata : ctl3_q;
            gap_q <= conv_clock_tick ? 10'h001 : gap_q + {9'h0, gap_q != 10'h3ff};
            seen_q <= seen_q | conv_clock_tick;
        end
    end

    // ==========================================================
    // Assertions
    sequence samp_end;
        $past(sampling) && !sampling;
    endsequence
    ref_decode_a: assert property (!wr_two [*3] |-> ref_sel == {~ctl2_q[15] & ctl2_q[13], ~ctl2_q[15] & ctl2_q[14]})
        else $error("reference select differs from field");
    offset_cal_a: assert property (sampling && ctl2_q[12] |-> sampler_sel.pos_low_ref && !sampler_sel.neg_an1)
        else $error("offset calibration not tied low");
    conv_after_a: assert property (convert_start |-> samp_end)
        else $error("convert start without end of sampling");
    write_done_a: assert property (result_wr_en |-> $past(conv_done))
        else $error("result write without conversion done");
    irq_write_a: assert property (seq_irq |-> result_wr_en)
        else $error("interrupt without completed sequence");
    tick_gap_a: assert property (conv_clock_tick && seen_q && !ctl3_q[15] |-> gap_q >= period)
        else $error("conversion tick too early");
    rc_tick_a: assert property (conv_clock_tick && ctl3_q[15] |-> $past(rc_clock_tick) || $past(rc_clock_tick, 2))
        else $error("conversion tick without rc tick");
    read_zero_a: assert property (acc && !pwrite |-> (prdata & ~rmask) == 32'h0)
        else $error("unimplemented bits read nonzero");
endmodule

bind asc_adc_sequence_control asc_checker i_chk (.*);

// file: dv/asc_conv_model.sv
// Behavioural converter: answers a conversion after some clock ticks.
// Assumes convert_start and conv_clock_tick come from the control block.
`timescale 1ns/1ps
module asc_conv_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Handshake
    input wire logic convert_start,
    input wire logic conv_clock_tick,
    input wire logic slow,
    output logic conv_done
);
    logic busy_q;
    logic [3:0] cnt_q;
    // Ten-bit result takes twelve ticks when slow
    wire [3:0] need = slow ? 4'hb : 4'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= busy_q && conv_clock_tick && cnt_q == need;
            if (convert_start) begin
                busy_q <= 1'b1;
                cnt_q <= 4'h0;
            end else if (busy_q && conv_clock_tick) begin
                busy_q <= cnt_q != need;
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// file: dv/asc_adc_sequence_control_bench.sv
// Self-checking bench for the converter sequence control.
// Assumes the bound checker and the converter model beside the design.
`timescale 1ns/1ps
module asc_adc_sequence_control_bench;
    import asc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, ext_end_sample, rc_clock_tick, conv_done, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic pready, pslverr, conv_clock_tick, sampling, convert_start, result_wr_en, seq_irq, slv_q;
    logic [3:0] result_wr_addr;
    asc_sampler_sel_t sampler_sel;
    asc_ref_sel_t ref_sel;
    int err_count = 0;
    int samples_checked = 0;
    int gap = 0, last_gap = 0, ts = 0, irqs = 0, scnt = 0, rcnt = 0;
    bit rc_on = 0;
    logic [6:0] sel_last;
    logic [6:0] selq[$];
    logic [3:0] aq[$];
    int tq[$];
    logic [6:0] scan_exp [4] = '{7'h04, 7'h1a, 7'h3e, 7'h04};

    asc_adc_sequence_control i_dut (.*);
    asc_conv_model i_conv (.*);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ==========================================================
    // Monitor and far-side stimulus
    always @(posedge pclk) begin
        gap++;
        if (conv_clock_tick === 1'b1) begin
            last_gap = gap;
            gap = 0;
        end
        if (sampling === 1'b1) sel_last = sampler_sel;
        // Last tick of the sample time rises together with convert_start
        if (sampling === 1'b1 || convert_start === 1'b1) ts += (conv_clock_tick === 1'b1);
        if (convert_start === 1'b1) begin
            selq.push_back(sel_last);
            tq.push_back(ts);
            ts = 0;
        end
        if (result_wr_en === 1'b1) aq.push_back(result_wr_addr);
        if (seq_irq === 1'b1) irqs++;
        scnt = (sampling === 1'b1) ? scnt + 1 : 0;
        ext_end_sample <= scnt == 5;
        rcnt = (rcnt + 1) % 10;
        rc_clock_tick <= rc_on && rcnt == 0;
    end

    // ==========================================================
    // Tasks
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            end_of_test();
        end
        rd_q = prdata;
        slv_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("prdata", exp, rd_q);
    endtask

    task automatic run(input logic [2:0] trig, input int n);
        int k;
        selq.delete();
        aq.delete();
        tq.delete();
        irqs = 0;
        ts = 0;
        apb(1'b1, ADDR_SEQ_CTL, {24'h0, trig, 5'h05});
        k = 0;
        while (aq.size() < n && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        if (aq.size() < n) begin
            err_count++;
            end_of_test();
        end
        apb(1'b1, ADDR_SEQ_CTL, 32'h0000_0002);
        repeat (4) @(posedge pclk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, slow, presetn} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
        rd(8'h18, 32'h0);
        chk("pslverr", 32'h1, slv_q);
        apb(1'b1, ADDR_CTL_TWO, 32'hffff_ffff);
        rd(ADDR_CTL_TWO, 32'h0000_f43f);
        apb(1'b1, ADDR_CTL_THREE, 32'hffff_ffff);
        rd(ADDR_CTL_THREE, 32'h0000_9fff);
        apb(1'b1, ADDR_INPUT_SEL, 32'hffff_ffff);
        rd(ADDR_INPUT_SEL, 32'h8f8f_0000);
        apb(1'b1, ADDR_SCAN_SEL, 32'hffff_ffff);
        rd(ADDR_SCAN_SEL, 32'h0000_ffff);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_CTL_TWO, 32'(i) << 13);
            repeat (3) @(posedge pclk);
            chk("ref_sel", {30'h0, ~i[2] & i[0], ~i[2] & i[1]}, ref_sel);
        end
        // Auto trigger, split buffer, alternate A/B
        apb(1'b1, ADDR_INPUT_SEL, 32'h8503_0000);
        apb(1'b1, ADDR_CTL_THREE, 32'h0000_0202);
        apb(1'b1, ADDR_CTL_TWO, 32'h0000_000b);
        run(TRIG_AUTO, 5);
        for (int i = 0; i < 5; i++) begin
            chk("wr_addr", i < 3 ? i : i + 5, aq[i]);
            chk("sampler_sel", i % 2 ? 32'h0b : 32'h06, selq[i]);
            chk("sample_ticks", 2, tq[i]);
        end
        chk("irq_count", 1, irqs);
        chk("tick_gap", 6, last_gap);
        rd(ADDR_CTL_TWO, 32'h0000_008b);
        rd(ADDR_SEQ_STAT, 32'h0000_0202);
        // External trigger, scan, interrupt every sequence
        apb(1'b1, ADDR_SCAN_SEL, 32'h0000_a004);
        apb(1'b1, ADDR_CTL_THREE, 32'h0000_0100);
        apb(1'b1, ADDR_CTL_TWO, 32'h0000_0400);
        slow <= 1'b1;
        run(3'h0, 4);
        for (int i = 0; i < 4; i++) begin
            chk("wr_addr", 0, aq[i]);
            chk("scan_sel", scan_exp[i], selq[i]);
        end
        chk("irq_count", 4, irqs);
        chk("ext_ticks", 1, tq[0] > 1);
        chk("tick_gap", 2, last_gap);
        // RC clock with offset calibration
        apb(1'b1, ADDR_CTL_THREE, 32'h0000_8100);
        apb(1'b1, ADDR_CTL_TWO, 32'h0000_7000);
        rc_on = 1;
        run(TRIG_AUTO, 2);
        chk("offset_cal", 32'h2, {selq[0][6], selq[0][0]});
        chk("rc_gap", 10, last_gap);
        chk("ref_sel", 3, ref_sel);
        chk("rc_ticks", 1, tq[0]);
        end_of_test();
    end
endmodule
